/* shared/cif_pkg.sv */
// Constants shared by the CPU interface register block
`default_nettype none
package cif_pkg;
  localparam int ADDR_W = 13;
  localparam int ID_W = 10;
  localparam int PRIO_W = 8;
  localparam int BPR_W = 3;
  // Byte offsets within one CPU interface
  localparam logic [12:0] OFF_CTL = 13'h0000;
  localparam logic [12:0] OFF_PMR = 13'h0004;
  localparam logic [12:0] OFF_BPR = 13'h0008;
  localparam logic [12:0] OFF_IAR = 13'h000C;
  localparam logic [12:0] OFF_EOIR = 13'h0010;
  localparam logic [12:0] OFF_RPR = 13'h0014;
  localparam logic [12:0] OFF_HPPIR = 13'h0018;
  localparam logic [12:0] OFF_ABPR = 13'h001C;
  localparam logic [12:0] OFF_AIAR = 13'h0020;
  localparam logic [12:0] OFF_AEOIR = 13'h0024;
  localparam logic [12:0] OFF_AHPPIR = 13'h0028;
  localparam logic [12:0] OFF_APR = 13'h00D0;
  localparam logic [12:0] OFF_NSAPR = 13'h00E0;
  localparam logic [12:0] OFF_IIDR = 13'h00FC;
  localparam logic [12:0] OFF_DIR = 13'h1000;
  // Control field positions
  localparam int CTL_G0_BIT = 0;
  localparam int CTL_G1_BIT = 1;
  localparam int CTL_ACK_BIT = 2;
  localparam int CTL_NS_G1_BIT = 0;
  // Values after reset
  localparam logic [9:0] SPURIOUS_ID = 10'h3FF;
  localparam logic [7:0] RST_PMR = 8'h00;
  localparam logic [7:0] IDLE_PRIO = 8'hFF;
  localparam logic [2:0] RST_BPR_S = 3'h2;
  localparam logic [2:0] RST_BPR_NS = 3'h3;
  localparam logic [31:0] RST_APR = 32'h00000000;
  // Arbitrary identification value, names no maker
  localparam logic [31:0] IIDR_VALUE = 32'h0001A5C0;
endpackage : cif_pkg
`default_nettype wire

/* core/cif_gate.sv */
// Distributor group gating of the highest pending interrupt
`timescale 1ns/1ps
`default_nettype none
module cif_gate #(
  parameter int NUM_CPU = 8
) (
  input wire logic dist_grp0_en,
  input wire logic dist_grp1_en,
  input wire logic [NUM_CPU-1:0] hp_valid,
  input wire logic [NUM_CPU-1:0] hp_group,
  output logic [NUM_CPU-1:0] fwd_valid
);
  // The candidate is the overall highest pending one, so a candidate
  // in a disabled group blocks every lower one behind it
  always_comb begin
    for (int c = 0; c < NUM_CPU; c++) begin
      fwd_valid[c] = hp_valid[c] && (hp_group[c] ? dist_grp1_en : dist_grp0_en); // R9 R14
    end
  end
  // Both enables low forwards nothing; acknowledge reads see spurious // R11 R12
  // Pending state is set upstream, enables do not gate it here // R13
endmodule : cif_gate
`default_nettype wire

/* core/cif_ack.sv */
// Decides which group an acknowledge or pending read may return
`timescale 1ns/1ps
`default_nettype none
module cif_ack (
  input wire logic fwd_valid,
  input wire logic fwd_group,
  input wire logic [9:0] fwd_id,
  input wire logic pri_ok,
  input wire logic g0en,
  input wire logic g1en,
  input wire logic acknowledge_control,
  input wire logic secure,
  input wire logic aliased,
  output logic hit,
  output logic [9:0] id
);
  logic take_g0;
  logic take_g1;
  always_comb begin
    take_g0 = 1'b0;
    take_g1 = 1'b0;
    if (aliased) begin
      take_g1 = g1en; // R17 R21
    end else if (!secure) begin
      take_g1 = g1en; // R19
    end else if (!acknowledge_control) begin
      take_g0 = g0en; // R16
    end else if (!g0en) begin
      take_g1 = g1en; // R20
    end else begin
      take_g0 = 1'b1;
      take_g1 = g1en;
    end
    // Disabled group reports spurious on the pending view too // R18
    hit = fwd_valid && pri_ok && (fwd_group ? take_g1 : take_g0);
    id = hit ? fwd_id : cif_pkg::SPURIOUS_ID;
  end
endmodule : cif_ack
`default_nettype wire

/* core/cif_top.sv */
// CPU interface register banks, enable gating and acknowledge logic
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - registers 32 bits, reserved read zero
// R2 - one register copy per CPU interface
// R3 - same offsets for every processor
// R4 - full word accesses honour access type
// R5 - halfword access support is our choice
// R6 - sub-word lanes little endian
// R7 - secure and non-secure banked copies
// R8 - per-processor banking of private state
// R9 - distributor group enables gate forwarding
// R10 - interface group enables gate signalling
// R11 - both distributor groups off: nothing forwarded
// R12 - both off: acknowledge reads return spurious
// R13 - pending while disabled is implementation choice
// R14 - one group off blocks its top candidate
// R15 - software keeps group 0 above group 1
// R16 - group 0 off: acknowledge read spurious
// R17 - group 1 off: aliased acknowledge spurious
// R18 - disabled group pending view is our choice
// R19 - legacy mode, group 1 off: non-secure spurious
// R20 - legacy mode, only group 1: acknowledge aliases
// R21 - legacy mode, group 1 off: aliased spurious
// R22 - software should keep legacy mode off
// R23 - read-only writes ignored, write-only reads zero
// R24 - reset loads all listed values
module cif_top #(
  parameter int NUM_CPU = 8,
  localparam int CPU_W = (NUM_CPU > 1) ? $clog2(NUM_CPU) : 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [12:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_secure,
  input wire logic [CPU_W-1:0] reg_cpu,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic dist_grp0_en,
  input wire logic dist_grp1_en,
  input wire logic [NUM_CPU-1:0] hp_valid,
  input wire logic [NUM_CPU-1:0] hp_group,
  input wire logic [NUM_CPU-1:0][9:0] hp_id,
  input wire logic [NUM_CPU-1:0][7:0] hp_prio,
  output logic [NUM_CPU-1:0] cpu_irq,
  output logic ack_valid,
  output logic [9:0] ack_id,
  output logic [CPU_W-1:0] ack_cpu,
  output logic eoi_valid,
  output logic [9:0] eoi_id,
  output logic [CPU_W-1:0] eoi_cpu,
  output logic dir_valid,
  output logic [9:0] dir_id,
  output logic [CPU_W-1:0] dir_cpu
);
  if (NUM_CPU < 1 || NUM_CPU > 8) begin : g_num_cpu_check
    $error("NUM_CPU must lie in 1..8");
  end

  //////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NUM_CPU-1:0] g0en;
    logic [NUM_CPU-1:0] g1en;
    logic [NUM_CPU-1:0] acknowledge_control;
    logic [NUM_CPU-1:0][2:0] bpr_s;
    logic [NUM_CPU-1:0][2:0] bpr_ns;
    logic [NUM_CPU-1:0][7:0] pmr;
    logic [NUM_CPU-1:0][7:0] rpr;
    logic [NUM_CPU-1:0][31:0] apr;
    logic [NUM_CPU-1:0][31:0] nsapr;
    logic [NUM_CPU-1:0] irq;
    logic [31:0] rdata;
    logic ack;
    logic ack_v;
    logic [9:0] ack_id;
    logic [CPU_W-1:0] ack_cpu;
    logic eoi_v;
    logic [9:0] eoi_id;
    logic [CPU_W-1:0] eoi_cpu;
    logic dir_v;
    logic [9:0] dir_id;
    logic [CPU_W-1:0] dir_cpu;
  } cif_state_s;

  cif_state_s st;
  cif_state_s next_st;

  // Byte lanes merge low address to low bits
  function automatic logic [31:0] cif_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8]; // R6
      end
    end
    return res;
  endfunction : cif_merge

  //////////////////////////////////////////////////////////////////
  logic [NUM_CPU-1:0] fwd_valid;
  logic cpu_ok;
  logic rd;
  logic wr;
  logic is_ack_addr;
  logic is_alias;
  logic cur_g0;
  logic cur_g1;
  logic cur_acknowledge_control;
  logic cur_pri_ok;
  logic sel_hit;
  logic [9:0] sel_id;

  cif_gate #(
    .NUM_CPU(NUM_CPU)
  ) u_gate (
    .dist_grp0_en(dist_grp0_en),
    .dist_grp1_en(dist_grp1_en),
    .hp_valid(hp_valid),
    .hp_group(hp_group),
    .fwd_valid(fwd_valid)
  );

  // Every processor uses the same offsets; reg_cpu picks its own copy
  assign cpu_ok = 32'(reg_cpu) < NUM_CPU; // R2 R3
  assign rd = reg_req && !reg_wr && cpu_ok;
  assign wr = reg_req && reg_wr && cpu_ok;
  assign is_ack_addr = reg_addr == cif_pkg::OFF_IAR || reg_addr == cif_pkg::OFF_AIAR;
  assign is_alias = reg_addr == cif_pkg::OFF_AIAR || reg_addr == cif_pkg::OFF_AHPPIR;
  assign cur_g0 = st.g0en[reg_cpu];
  assign cur_g1 = st.g1en[reg_cpu];
  assign cur_acknowledge_control = st.acknowledge_control[reg_cpu];
  // Only acknowledges honour the mask; the pending view ignores it
  assign cur_pri_ok = !is_ack_addr
    || (hp_prio[reg_cpu] < st.pmr[reg_cpu] && hp_prio[reg_cpu] < st.rpr[reg_cpu]);

  cif_ack u_ack (
    .fwd_valid(fwd_valid[reg_cpu]),
    .fwd_group(hp_group[reg_cpu]),
    .fwd_id(hp_id[reg_cpu]),
    .pri_ok(cur_pri_ok),
    .g0en(cur_g0),
    .g1en(cur_g1),
    .acknowledge_control(cur_acknowledge_control),
    .secure(reg_secure),
    .aliased(is_alias),
    .hit(sel_hit),
    .id(sel_id)
  );

  //////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.ack = reg_req;
    next_st.ack_v = 1'b0;
    next_st.eoi_v = 1'b0;
    next_st.dir_v = 1'b0;
    next_st.rdata = '0;
    for (int c = 0; c < NUM_CPU; c++) begin
      next_st.irq[c] = fwd_valid[c]
        && (hp_group[c] ? st.g1en[c] : st.g0en[c]) // R10
        && hp_prio[c] < st.pmr[c] && hp_prio[c] < st.rpr[c];
    end
    if (rd) begin
      case (reg_addr)
        cif_pkg::OFF_CTL: begin
          if (reg_secure) begin
            next_st.rdata[cif_pkg::CTL_G0_BIT] = cur_g0; // R7
            next_st.rdata[cif_pkg::CTL_G1_BIT] = cur_g1;
            next_st.rdata[cif_pkg::CTL_ACK_BIT] = cur_acknowledge_control;
          end else begin
            next_st.rdata[cif_pkg::CTL_NS_G1_BIT] = cur_g1;
          end
        end
        cif_pkg::OFF_PMR: next_st.rdata[7:0] = st.pmr[reg_cpu];
        cif_pkg::OFF_BPR: begin
          next_st.rdata[2:0] = reg_secure ? st.bpr_s[reg_cpu] : st.bpr_ns[reg_cpu]; // R7
        end
        cif_pkg::OFF_RPR: next_st.rdata[7:0] = st.rpr[reg_cpu];
        cif_pkg::OFF_IAR, cif_pkg::OFF_HPPIR: begin
          next_st.rdata[9:0] = sel_id; // R12 R16 R19 R20
        end
        cif_pkg::OFF_AIAR, cif_pkg::OFF_AHPPIR: begin
          if (reg_secure) begin
            next_st.rdata[9:0] = sel_id; // R17 R21
          end
        end
        cif_pkg::OFF_ABPR: begin
          if (reg_secure) begin
            next_st.rdata[2:0] = st.bpr_ns[reg_cpu];
          end
        end
        cif_pkg::OFF_APR: next_st.rdata = st.apr[reg_cpu]; // R8
        cif_pkg::OFF_NSAPR: begin
          if (reg_secure) begin
            next_st.rdata = st.nsapr[reg_cpu];
          end
        end
        cif_pkg::OFF_IIDR: next_st.rdata = cif_pkg::IIDR_VALUE;
        // Write-only and reserved offsets read as zero
        default: next_st.rdata = '0; // R1 R23
      endcase
      // Acknowledge takes the interrupt and raises running priority
      if (is_ack_addr && sel_hit && (reg_secure || !is_alias)) begin
        next_st.ack_v = 1'b1;
        next_st.ack_id = sel_id;
        next_st.ack_cpu = reg_cpu;
        next_st.rpr[reg_cpu] = hp_prio[reg_cpu];
      end
    end
    if (wr) begin
      case (reg_addr)
        cif_pkg::OFF_CTL: begin
          if (reg_be[0]) begin
            if (reg_secure) begin
              next_st.g0en[reg_cpu] = reg_wdata[cif_pkg::CTL_G0_BIT]; // R7
              next_st.g1en[reg_cpu] = reg_wdata[cif_pkg::CTL_G1_BIT];
              next_st.acknowledge_control[reg_cpu] = reg_wdata[cif_pkg::CTL_ACK_BIT]; // R22
            end else begin
              next_st.g1en[reg_cpu] = reg_wdata[cif_pkg::CTL_NS_G1_BIT]; // R7
            end
          end
        end
        cif_pkg::OFF_PMR: begin
          if (reg_be[0]) begin
            next_st.pmr[reg_cpu] = reg_wdata[7:0];
          end
        end
        cif_pkg::OFF_BPR: begin
          if (reg_be[0] && reg_secure) begin
            next_st.bpr_s[reg_cpu] = reg_wdata[2:0];
          end else if (reg_be[0]) begin
            next_st.bpr_ns[reg_cpu] = reg_wdata[2:0];
          end
        end
        cif_pkg::OFF_ABPR: begin
          if (reg_be[0] && reg_secure) begin
            next_st.bpr_ns[reg_cpu] = reg_wdata[2:0];
          end
        end
        cif_pkg::OFF_EOIR, cif_pkg::OFF_AEOIR: begin
          if (reg_secure || reg_addr == cif_pkg::OFF_EOIR) begin
            next_st.eoi_v = 1'b1;
            next_st.eoi_id = reg_wdata[9:0];
            next_st.eoi_cpu = reg_cpu;
            // Single active level: completion drops back to idle
            next_st.rpr[reg_cpu] = cif_pkg::IDLE_PRIO;
          end
        end
        cif_pkg::OFF_DIR: begin
          next_st.dir_v = 1'b1;
          next_st.dir_id = reg_wdata[9:0];
          next_st.dir_cpu = reg_cpu;
        end
        cif_pkg::OFF_APR: begin
          next_st.apr[reg_cpu] = cif_merge(st.apr[reg_cpu], reg_wdata, reg_be); // R5 R8
        end
        cif_pkg::OFF_NSAPR: begin
          if (reg_secure) begin
            next_st.nsapr[reg_cpu] = cif_merge(st.nsapr[reg_cpu], reg_wdata, reg_be);
          end
        end
        // Read-only and reserved offsets ignore writes
        default: next_st.rdata = '0; // R1 R4 R23
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0; // R24
      st.pmr <= {NUM_CPU{cif_pkg::RST_PMR}};
      st.rpr <= {NUM_CPU{cif_pkg::IDLE_PRIO}};
      st.bpr_s <= {NUM_CPU{cif_pkg::RST_BPR_S}};
      st.bpr_ns <= {NUM_CPU{cif_pkg::RST_BPR_NS}};
      st.apr <= {NUM_CPU{cif_pkg::RST_APR}};
      st.nsapr <= {NUM_CPU{cif_pkg::RST_APR}};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_ack = st.ack;
  assign cpu_irq = st.irq;
  assign ack_valid = st.ack_v;
  assign ack_id = st.ack_id;
  assign ack_cpu = st.ack_cpu;
  assign eoi_valid = st.eoi_v;
  assign eoi_id = st.eoi_id;
  assign eoi_cpu = st.eoi_cpu;
  assign dir_valid = st.dir_v;
  assign dir_id = st.dir_id;
  assign dir_cpu = st.dir_cpu;

  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_iar_read;
    rd && reg_addr == cif_pkg::OFF_IAR;
  endsequence
  sequence s_aiar_read;
    rd && reg_addr == cif_pkg::OFF_AIAR && reg_secure;
  endsequence
  sequence s_eoi_write;
    wr && reg_addr == cif_pkg::OFF_EOIR;
  endsequence

  a_request_answered: assert property (reg_req |=> reg_ack) // R4
    else $error("register request not answered next cycle");
  a_reserved_reads_zero: assert property ( // R1
    rd && reg_addr == 13'h0030 |=> reg_rdata == 32'h00000000)
    else $error("reserved offset read non-zero");
  a_ro_write_ignored: assert property ( // R23
    wr && reg_addr == cif_pkg::OFF_RPR |=> $stable(st.rpr) && !ack_valid)
    else $error("write to read-only register had an effect");
  a_dist_off_spur: assert property ( // R12
    s_iar_read ##0 (!dist_grp0_en && !dist_grp1_en)
    |=> reg_rdata[9:0] == cif_pkg::SPURIOUS_ID && !ack_valid)
    else $error("acknowledge not spurious with distributor off");
  a_g0_off_spur: assert property ( // R16
    s_iar_read ##0 (reg_secure && !cur_acknowledge_control && !cur_g0)
    |=> reg_rdata[9:0] == cif_pkg::SPURIOUS_ID)
    else $error("acknowledge not spurious with group 0 off");
  a_alias_g1_off: assert property ( // R17 R21
    s_aiar_read ##0 !cur_g1 |=> reg_rdata[9:0] == cif_pkg::SPURIOUS_ID)
    else $error("aliased acknowledge not spurious with group 1 off");
  a_ns_iar_g1_off: assert property ( // R19
    s_iar_read ##0 (!reg_secure && cur_acknowledge_control && !cur_g1)
    |=> reg_rdata[9:0] == cif_pkg::SPURIOUS_ID)
    else $error("non-secure acknowledge not spurious");
  a_ack_pulse_pairs: assert property ( // R20
    s_iar_read |=> ack_valid == (reg_rdata[9:0] != cif_pkg::SPURIOUS_ID))
    else $error("acknowledge pulse disagrees with read data");
  a_iface_off_quiet: assert property ( // R10
    (st.g0en | st.g1en) == '0 |=> cpu_irq == '0)
    else $error("signalled with both interface groups off");
  a_dist_off_quiet: assert property ( // R9 R11
    !dist_grp0_en && !dist_grp1_en |=> cpu_irq == '0)
    else $error("signalled with distributor groups off");
  a_ns_ctl_bank: assert property ( // R7
    wr && reg_addr == cif_pkg::OFF_CTL && !reg_secure && reg_be[0]
    |=> $stable(st.g0en) && $stable(st.acknowledge_control))
    else $error("non-secure control write reached secure bits");
  a_eoi_idles: assert property ( // R24
    s_eoi_write |=> eoi_valid ##1 !eoi_valid || $past(reg_req))
    else $error("end of interrupt pulse malformed");
endmodule : cif_top
`default_nettype wire

/* sim/cif_core_model.sv */
// Processor core model that issues register accesses to its CPU interface
`timescale 1ns/1ps
`default_nettype none
module cif_core_model (
  input wire logic core_clk,
  output logic reg_req,
  output logic reg_wr,
  output logic [12:0] reg_addr,
  output logic [3:0] reg_be,
  output logic [31:0] reg_wdata,
  output logic reg_secure,
  output logic [0:0] reg_cpu
);
  initial begin
    reg_req = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 13'h0000;
    reg_be = 4'h0;
    reg_wdata = 32'h00000000;
    reg_secure = 1'b0;
    reg_cpu = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // The block takes a request as a single-cycle pulse and answers one cycle later
  task automatic access(input logic wr, input logic [12:0] addr, input logic [3:0] be,
                        input logic [31:0] data, input logic sec, input logic [0:0] cpu);
    @(posedge core_clk);
    #1;
    reg_wr = wr;
    reg_addr = addr;
    reg_be = be;
    reg_wdata = data;
    reg_secure = sec;
    reg_cpu = cpu;
    reg_req = 1'b1;
    @(posedge core_clk);
    #1;
    reg_req = 1'b0;
    // Released address and data lines show junk so a stale value is never mistaken for a live one
    reg_wdata = ~reg_wdata;
    reg_addr = ~reg_addr;
  endtask : access
endmodule : cif_core_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the CPU interface register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int NCPU = 2;
  typedef struct packed {
    logic [31:0] data;
    logic ackv;
  } cif_note_s;
  logic core_clk;
  logic resetn;
  logic reg_req;
  logic reg_wr;
  logic [12:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata;
  logic reg_secure;
  logic [0:0] reg_cpu;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic dist_grp0_en;
  logic dist_grp1_en;
  logic [NCPU-1:0] hp_valid;
  logic [NCPU-1:0] hp_group;
  logic [NCPU-1:0][9:0] hp_id;
  logic [NCPU-1:0][7:0] hp_prio;
  logic [NCPU-1:0] cpu_irq;
  logic ack_valid;
  logic [9:0] ack_id;
  logic [0:0] ack_cpu;
  logic eoi_valid;
  logic [9:0] eoi_id;
  logic [0:0] eoi_cpu;
  logic dir_valid;
  logic [9:0] dir_id;
  logic [0:0] dir_cpu;
  cif_note_s notes[$];
  cif_note_s note;
  int err_count;
  int checked;
  int cycles;
  int eoi_seen;
  logic [9:0] rid;
  logic [7:0] rprio;
  logic [9:0] eoi_exp;

  cif_core_model u_cif_core_model (.core_clk(core_clk), .reg_req(reg_req), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_secure(reg_secure),
    .reg_cpu(reg_cpu));
  cif_top #(.NUM_CPU(NCPU)) u_cif_top (.core_clk(core_clk), .resetn(resetn),
    .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_secure(reg_secure), .reg_cpu(reg_cpu),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .dist_grp0_en(dist_grp0_en),
    .dist_grp1_en(dist_grp1_en), .hp_valid(hp_valid), .hp_group(hp_group), .hp_id(hp_id),
    .hp_prio(hp_prio), .cpu_irq(cpu_irq), .ack_valid(ack_valid), .ack_id(ack_id),
    .ack_cpu(ack_cpu), .eoi_valid(eoi_valid), .eoi_id(eoi_id), .eoi_cpu(eoi_cpu),
    .dir_valid(dir_valid), .dir_id(dir_id), .dir_cpu(dir_cpu));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [12:0] addr, input logic sec, input logic [0:0] cpu,
                    input logic [31:0] exp, input logic ackv);
    notes.push_back('{exp, ackv});
    u_cif_core_model.access(1'b0, addr, 4'hF, 32'h00000000, sec, cpu);
  endtask : rd
  task automatic wr(input logic [12:0] addr, input logic [3:0] be, input logic [31:0] data,
                    input logic sec);
    notes.push_back('{32'h00000000, 1'b0});
    u_cif_core_model.access(1'b1, addr, be, data, sec, 1'b0);
  endtask : wr
  task automatic fwd(input logic d0, input logic d1, input logic grp);
    @(posedge core_clk);
    #1;
    dist_grp0_en = d0;
    dist_grp1_en = d1;
    hp_group[0] = grp;
  endtask : fwd
  // Interrupt line is registered, so let the inputs settle first
  task automatic irq(input logic exp);
    repeat (3) @(posedge core_clk);
    check("cpu_irq", {30'h0, cpu_irq}, {31'h0, exp});
  endtask : irq
  task automatic wrap_up;
    repeat (3) @(posedge core_clk);
    check("pending answers", notes.size(), 32'h00000000);
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////
  // Every answer is matched against the oldest note left by the driver
  always @(posedge core_clk) begin
    if (reg_ack === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected answer", 32'h00000001, 32'h00000000);
      end else begin
        note = notes.pop_front();
        check("reg_rdata", reg_rdata, note.data);
        check("ack_valid", {31'h0, ack_valid}, {31'h0, note.ackv});
        if (note.ackv) check("ack_id", {21'h0, ack_cpu, ack_id}, note.data);
      end
    end
    if (eoi_valid === 1'b1) begin
      eoi_seen++;
      check("eoi_id", {21'h0, eoi_cpu, eoi_id}, {22'h0, eoi_exp});
    end
    // The deactivate in the test comes from the second processor
    if (dir_valid === 1'b1) begin
      eoi_seen++;
      check("dir", {21'h0, dir_cpu, dir_id}, {21'h0, 1'b1, eoi_exp});
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    dist_grp0_en = 1'b0;
    dist_grp1_en = 1'b0;
    hp_valid = '0;
    hp_group = '0;
    hp_id = '0;
    hp_prio = '0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    eoi_seen = 0;
    eoi_exp = 10'h000;
    void'($urandom(32'h22A7F084));
    rid = 10'($urandom_range(1000, 16));
    // Group 0 kept in the upper half of priority; the group 1 cases reuse the same value
    rprio = 8'($urandom_range(127, 0));
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    rd(cif_pkg::OFF_CTL, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(cif_pkg::OFF_PMR, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(cif_pkg::OFF_BPR, 1'b1, 1'b0, {29'h0, cif_pkg::RST_BPR_S}, 1'b0);
    rd(cif_pkg::OFF_BPR, 1'b0, 1'b0, {29'h0, cif_pkg::RST_BPR_NS}, 1'b0);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    rd(cif_pkg::OFF_RPR, 1'b1, 1'b0, 32'h000000FF, 1'b0);
    rd(cif_pkg::OFF_HPPIR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    rd(cif_pkg::OFF_AIAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    rd(cif_pkg::OFF_AHPPIR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    rd(cif_pkg::OFF_APR, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(cif_pkg::OFF_NSAPR, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(cif_pkg::OFF_IIDR, 1'b1, 1'b0, cif_pkg::IIDR_VALUE, 1'b0);
    rd(cif_pkg::OFF_EOIR, 1'b1, 1'b0, 32'h00000000, 1'b0);
    $display("test reset values done");
    wr(cif_pkg::OFF_IAR, 4'hF, 32'h00000055, 1'b1);
    wr(13'h002C, 4'hF, 32'hFFFFFFFF, 1'b1);
    rd(13'h002C, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(13'h0030, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    wr(cif_pkg::OFF_RPR, 4'hF, 32'h00000012, 1'b1);
    rd(cif_pkg::OFF_RPR, 1'b1, 1'b0, 32'h000000FF, 1'b0);
    wr(cif_pkg::OFF_APR, 4'b0100, 32'hA1B2C3D4, 1'b1);
    rd(cif_pkg::OFF_APR, 1'b1, 1'b0, 32'h00B20000, 1'b0);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000004, 1'b1);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000001, 1'b0);
    // The non-secure enable is a view of the secure group 1 enable
    rd(cif_pkg::OFF_CTL, 1'b1, 1'b0, 32'h00000006, 1'b0);
    rd(cif_pkg::OFF_CTL, 1'b0, 1'b0, 32'h00000001, 1'b0);
    rd(cif_pkg::OFF_ABPR, 1'b0, 1'b0, 32'h00000000, 1'b0);
    wr(cif_pkg::OFF_ABPR, 4'hF, 32'h00000005, 1'b1);
    rd(cif_pkg::OFF_BPR, 1'b0, 1'b0, 32'h00000005, 1'b0);
    notes.push_back('{32'h00000000, 1'b0});
    u_cif_core_model.access(1'b1, cif_pkg::OFF_PMR, 4'hF, 32'h00000080, 1'b1, 1'b1);
    rd(cif_pkg::OFF_PMR, 1'b1, 1'b0, 32'h00000000, 1'b0);
    rd(cif_pkg::OFF_PMR, 1'b1, 1'b1, 32'h00000080, 1'b0);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000000, 1'b0);
    $display("test access kinds and banking done");
    wr(cif_pkg::OFF_PMR, 4'hF, 32'h000000F0, 1'b1);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000001, 1'b1);
    hp_valid[0] = 1'b1;
    hp_id[0] = rid;
    hp_prio[0] = rprio;
    fwd(1'b0, 1'b0, 1'b0);
    irq(1'b0);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    rd(cif_pkg::OFF_HPPIR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    fwd(1'b1, 1'b0, 1'b0);
    irq(1'b1);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000000, 1'b1);
    irq(1'b0);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000001, 1'b1);
    irq(1'b1);
    rd(cif_pkg::OFF_HPPIR, 1'b1, 1'b0, {22'h0, rid}, 1'b0);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, {22'h0, rid}, 1'b1);
    rd(cif_pkg::OFF_RPR, 1'b1, 1'b0, {24'h0, rprio}, 1'b0);
    irq(1'b0);
    eoi_exp = rid;
    wr(cif_pkg::OFF_EOIR, 4'hF, {22'h0, rid}, 1'b1);
    rd(cif_pkg::OFF_RPR, 1'b1, 1'b0, 32'h000000FF, 1'b0);
    $display("test group 0 gating done");
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000003, 1'b1);
    fwd(1'b1, 1'b0, 1'b1);
    irq(1'b0);
    fwd(1'b1, 1'b1, 1'b1);
    irq(1'b1);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000001, 1'b1);
    irq(1'b0);
    rd(cif_pkg::OFF_AIAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    // Deprecated acknowledge mode still has to behave
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000005, 1'b1);
    rd(cif_pkg::OFF_AIAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    rd(cif_pkg::OFF_IAR, 1'b0, 1'b0, 32'h000003FF, 1'b0);
    wr(cif_pkg::OFF_CTL, 4'hF, 32'h00000006, 1'b1);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, {22'h0, rid}, 1'b1);
    wr(cif_pkg::OFF_EOIR, 4'hF, {22'h0, rid}, 1'b1);
    notes.push_back('{32'h00000000, 1'b0});
    u_cif_core_model.access(1'b1, cif_pkg::OFF_DIR, 4'hF, {22'h0, rid}, 1'b0, 1'b1);
    fwd(1'b1, 1'b1, 1'b0);
    rd(cif_pkg::OFF_IAR, 1'b1, 1'b0, 32'h000003FF, 1'b0);
    repeat (3) @(posedge core_clk);
    check("completion count", eoi_seen, 32'h00000003);
    $display("test group 1 and acknowledge modes done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
